/* File: hw/agp_defs.svh */
/*
 * Register offsets, field positions and reset values for the auxiliary
 * pin control block. Assumes inclusion by bare name from hw/.
 */
`ifndef AGP_DEFS_SVH
`define AGP_DEFS_SVH

// Register addresses on the device register port
`define AGP_ADDR_MODE_DIR      8'h16
`define AGP_ADDR_DRIVE_READ    8'h17

// Field positions, shared by both registers
`define AGP_MODE_LSB           8
`define AGP_DIR_LSB            0
`define AGP_LEVEL_LSB          8
`define AGP_INPUT_LSB          0

// Reset values
`define AGP_MODE_RESET         6'h3f
`define AGP_DIR_RESET          6'h00
`define AGP_LEVEL_RESET        6'h00

// Capture points inside a read transaction
`define AGP_SPI_CAPTURE_EDGE   4'h9

`endif

/* File: hw/agp_pin_cell.sv */
/*
 * One multifunction pin: pad control from mode, direction and level.
 * Assumes synchronous inputs on ref_clk; pad resolution is outside.
 */
`timescale 1ns/1ps

module agp_pin_cell
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_sync_b,
    input  wire logic clk_en,
    // Configuration
    input  wire logic digital_mode_sel,
    input  wire logic pin_direction,
    input  wire logic output_level,
    // Pad side
    input  wire logic pad_in,
    output logic      pad_out,
    output logic      pad_oe_b,
    output logic      pad_pulldown_en,
    output logic      pad_analog_en,
    // Buffered level, zero in analog mode
    output logic      input_level
);

    logic pad_out_nxt;   // Next drive value
    logic pad_oe_b_nxt;  // Next enable, low drives
    logic pd_nxt;        // Next pulldown enable
    logic an_nxt;        // Next analog enable
    logic in_nxt;        // Next buffered level

    // Pad control decode
    always_comb
    begin
        // Direction only counts in digital mode
        pad_oe_b_nxt = ~(digital_mode_sel & pin_direction);
        // Level only reaches the pad as an output
        pad_out_nxt  = digital_mode_sel & pin_direction & output_level;
        pd_nxt       = digital_mode_sel & ~pin_direction;
        an_nxt       = ~digital_mode_sel;
        // Input buffer stays live for outputs too
        in_nxt       = digital_mode_sel & pad_in;
    end

    // Registered pad controls
    always_ff @(posedge ref_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            pad_out         <= 1'b0;
            pad_oe_b        <= 1'b1;
            pad_pulldown_en <= 1'b1;
            pad_analog_en   <= 1'b0;
            input_level     <= 1'b0;
        end
        else if (clk_en)
        begin
            pad_out         <= pad_out_nxt;
            pad_oe_b        <= pad_oe_b_nxt;
            pad_pulldown_en <= pd_nxt;
            pad_analog_en   <= an_nxt;
            input_level     <= in_nxt;
        end
    end

endmodule

/* File: hw/agp_pin_control.sv */
/*
 * Auxiliary pin control: mode/direction and drive/readback registers
 * for six multifunction pins, with input capture tied to host reads.
 * Assumes the host serial front end supplies register strobes and
 * read-transaction events synchronous to ref_clk.
 */
// Overview of operation
// - Mode bit zero gives analog input
// - Direction bit one makes a digital output
// - Direction ignored in analog mode
// - Digital input enables weak pulldown
// - Output keeps input buffer active
// - Level bit sets driven logic value
// - Level applies only as digital output
// - Input-state bits report buffer level
// - Analog pins read input-state zero
// - UART read samples after address parity
// - SPI read samples on ninth SCLK
`timescale 1ns/1ps
`include "agp_defs.svh"

module agp_pin_control
    import agp_pkg::*;
#(
    parameter int NUM_PINS = 6
)
(
    // Clock, reset, enable
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                clk_en,
    // Register port from host interface
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    output logic      [15:0]         reg_rdata,
    // Host interface events
    input  wire logic                host_sel,
    input  wire logic                uart_addr_parity_end,
    input  wire logic                spi_cs_active,
    input  wire logic                spi_sclk_rise,
    input  wire logic                spi_read_cmd,
    // Pads
    input  wire logic [NUM_PINS-1:0] pad_in,
    output logic      [NUM_PINS-1:0] pad_out,
    output logic      [NUM_PINS-1:0] pad_oe_b,
    output logic      [NUM_PINS-1:0] pad_pulldown_en,
    output logic      [NUM_PINS-1:0] pad_analog_en
);

    // Reset synchroniser
    logic rst_meta_r;
    logic rst_sync_r;

    // Configuration and captured state
    logic [NUM_PINS-1:0] digital_mode_sel_r;   // Per-pin mode select
    logic [NUM_PINS-1:0] digital_mode_sel_nxt;
    logic [NUM_PINS-1:0] pin_direction_r;      // Per-pin direction
    logic [NUM_PINS-1:0] pin_direction_nxt;
    logic [NUM_PINS-1:0] output_level_r;       // Per-pin drive level
    logic [NUM_PINS-1:0] output_level_nxt;
    logic [NUM_PINS-1:0] input_level_r;        // Captured levels
    logic [NUM_PINS-1:0] input_level_nxt;
    logic [NUM_PINS-1:0] live_level;           // Buffered levels from cells
    logic [15:0]         reg_rdata_nxt;

    // SPI capture tracking
    agp_spi_state_type   spi_state_r;
    agp_spi_state_type   spi_state_nxt;
    logic [3:0]          sclk_cnt_r;
    logic [3:0]          sclk_cnt_nxt;
    logic                capture;

    // Place a pin vector at a field position of a 16-bit word
    function automatic logic [15:0] place(input logic [NUM_PINS-1:0] v, input int lsb);
        logic [15:0] w;
        w = 16'h0000;
        w[lsb +: NUM_PINS] = v;
        return w;
    endfunction

    // Two-flop reset release; assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Pin cells
    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
        agp_pin_cell u_cell
        (
            .ref_clk          (ref_clk),
            .rst_sync_b       (rst_sync_r),
            .clk_en           (clk_en),
            .digital_mode_sel (digital_mode_sel_r[i]),
            .pin_direction    (pin_direction_r[i]),
            .output_level     (output_level_r[i]),
            .pad_in           (pad_in[i]),
            .pad_out          (pad_out[i]),
            .pad_oe_b         (pad_oe_b[i]),
            .pad_pulldown_en  (pad_pulldown_en[i]),
            .pad_analog_en    (pad_analog_en[i]),
            .input_level      (live_level[i])
        );
    end

    // SPI tracker: count SCLK rises of a read frame, fire on the ninth
    always_comb
    begin
        spi_state_nxt = spi_state_r;
        sclk_cnt_nxt  = sclk_cnt_r;
        capture       = 1'b0;
        unique case (spi_state_r)
            AGP_SPI_IDLE:
            begin
                sclk_cnt_nxt = 4'h0;
                // Only SPI hosts use this path
                if (host_sel == AGP_HOST_SPI && spi_cs_active)
                    spi_state_nxt = AGP_SPI_COUNT;
            end
            AGP_SPI_COUNT:
            begin
                if (!spi_cs_active)
                    spi_state_nxt = AGP_SPI_IDLE;
                else if (spi_sclk_rise)
                begin
                    sclk_cnt_nxt = sclk_cnt_r + 4'h1;
                    if (sclk_cnt_nxt == `AGP_SPI_CAPTURE_EDGE)
                    begin
                        // Read flag known from the first byte by now
                        capture       = spi_read_cmd;
                        spi_state_nxt = AGP_SPI_DONE;
                    end
                end
            end
            AGP_SPI_DONE:
            begin
                // One capture per frame
                if (!spi_cs_active)
                    spi_state_nxt = AGP_SPI_IDLE;
            end
            default:
                spi_state_nxt = AGP_SPI_IDLE;
        endcase
        // UART front end flags the end of the address parity bit on reads
        if (host_sel == AGP_HOST_UART && uart_addr_parity_end)
            capture = 1'b1;
    end

    // Register next values
    always_comb
    begin
        digital_mode_sel_nxt = digital_mode_sel_r;
        pin_direction_nxt    = pin_direction_r;
        output_level_nxt     = output_level_r;
        input_level_nxt      = input_level_r;
        reg_rdata_nxt        = 16'h0000;
        if (reg_wr && reg_addr == `AGP_ADDR_MODE_DIR)
        begin
            digital_mode_sel_nxt = reg_wdata[`AGP_MODE_LSB +: NUM_PINS];
            pin_direction_nxt    = reg_wdata[`AGP_DIR_LSB +: NUM_PINS];
        end
        else if (reg_wr && reg_addr == `AGP_ADDR_DRIVE_READ)
        begin
            // Low byte is read-only; only the level field is taken
            output_level_nxt = reg_wdata[`AGP_LEVEL_LSB +: NUM_PINS];
        end
        // Live level is already zero for analog pins
        if (capture)
            input_level_nxt = live_level;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `AGP_ADDR_MODE_DIR:
                    reg_rdata_nxt = place(digital_mode_sel_r, `AGP_MODE_LSB)
                                  | place(pin_direction_r, `AGP_DIR_LSB);
                `AGP_ADDR_DRIVE_READ:
                    reg_rdata_nxt = place(output_level_r, `AGP_LEVEL_LSB)
                                  | place(input_level_nxt, `AGP_INPUT_LSB);
                default:
                    reg_rdata_nxt = 16'h0000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            digital_mode_sel_r <= NUM_PINS'(`AGP_MODE_RESET);
            pin_direction_r    <= NUM_PINS'(`AGP_DIR_RESET);
            output_level_r     <= NUM_PINS'(`AGP_LEVEL_RESET);
            input_level_r      <= '0;
            spi_state_r        <= AGP_SPI_IDLE;
            sclk_cnt_r         <= 4'h0;
            reg_rdata          <= 16'h0000;
        end
        else if (clk_en)
        begin
            digital_mode_sel_r <= digital_mode_sel_nxt;
            pin_direction_r    <= pin_direction_nxt;
            output_level_r     <= output_level_nxt;
            input_level_r      <= input_level_nxt;
            spi_state_r        <= spi_state_nxt;
            sclk_cnt_r         <= sclk_cnt_nxt;
            reg_rdata          <= reg_rdata_nxt;
        end
    end

endmodule

/* File: hw/agp_pkg.sv */
/*
 * Types for the auxiliary pin control block.
 * Assumes agp_defs.svh is compiled alongside.
 */
package agp_pkg;

    // Host serial interface that carries register reads
    typedef enum logic [0:0]
    {
        AGP_HOST_SPI  = 1'b0,
        AGP_HOST_UART = 1'b1
    } agp_host_type;

    // SPI read-capture tracker states
    typedef enum logic [1:0]
    {
        AGP_SPI_IDLE  = 2'b00,
        AGP_SPI_COUNT = 2'b01,
        AGP_SPI_DONE  = 2'b10
    } agp_spi_state_type;

endpackage

/* File: verification/agp_board_model.sv */
/*
 * Board circuitry on the six multifunction pins.
 * Assumes the testbench sets which pins the board drives.
 */
`timescale 1ns/1ps

module agp_board_model
(
    // Clock
    input  wire logic       ref_clk,
    // Device pad controls
    input  wire logic [5:0] pad_out,
    input  wire logic [5:0] pad_oe_b,
    input  wire logic [5:0] pad_pulldown_en,
    // Board sources
    input  wire logic [5:0] ext_drive,
    input  wire logic [5:0] ext_en,
    // Resolved pin level
    output logic      [5:0] pad_level
);
    logic [5:0] float_r = 6'h15; // Pattern on undriven pins

    // Flips every cycle so a floating pin never looks settled
    always @(posedge ref_clk) float_r <= ~float_r;
    // Device drive wins, then the board, then the weak pulldown
    always_comb
        for (int i = 0; i < 6; i++)
            pad_level[i] = !pad_oe_b[i] ? pad_out[i] : ext_en[i] ? ext_drive[i] :
                           pad_pulldown_en[i] ? 1'b0 : float_r[i];
endmodule

/* File: verification/agp_pin_control_properties.sv */
/*
 * Port checker for the auxiliary pin control block.
 * Assumes clk_en held high and pad controls one cycle behind registers.
 */
`timescale 1ns/1ps
`include "agp_defs.svh"

module agp_pin_control_properties #(parameter int NUM_PINS = 6)
(
    // Clock, reset, enable
    input wire logic                ref_clk,
    input wire logic                rst_b,
    input wire logic                clk_en,
    // Register port
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_addr,
    input wire logic [15:0]         reg_wdata,
    input wire logic [15:0]         reg_rdata,
    // Host events
    input wire logic                host_sel,
    input wire logic                uart_addr_parity_end,
    input wire logic                spi_cs_active,
    input wire logic                spi_sclk_rise,
    input wire logic                spi_read_cmd,
    // Pads
    input wire logic [NUM_PINS-1:0] pad_in,
    input wire logic [NUM_PINS-1:0] pad_out,
    input wire logic [NUM_PINS-1:0] pad_oe_b,
    input wire logic [NUM_PINS-1:0] pad_pulldown_en,
    input wire logic [NUM_PINS-1:0] pad_analog_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Write steps to each register, and the UART capture read
    sequence mode_wr_s; clk_en && reg_wr && reg_addr == `AGP_ADDR_MODE_DIR; endsequence
    sequence lvl_wr_s; clk_en && reg_wr && reg_addr == `AGP_ADDR_DRIVE_READ; endsequence
    sequence uart_rd_s;
        host_sel && uart_addr_parity_end && reg_rd && reg_addr == `AGP_ADDR_DRIVE_READ;
    endsequence

    mode_write_a: assert property (mode_wr_s ##1 clk_en |=>
        pad_analog_en == ~$past(reg_wdata[13:8], 2)) else $error("mode not applied");
    dir_apply_a: assert property (mode_wr_s ##1 clk_en |=>
        pad_oe_b == ~($past(reg_wdata[13:8], 2) & $past(reg_wdata[5:0], 2)))
        else $error("direction not applied");
    pulldown_match_a: assert property (pad_pulldown_en == (pad_oe_b & ~pad_analog_en))
        else $error("pulldown wrong");
    analog_quiet_a: assert property ((pad_analog_en & ~pad_oe_b) == 6'h00)
        else $error("analog pin driven");
    level_drive_a: assert property (lvl_wr_s ##1 clk_en |=>
        ((pad_out ^ $past(reg_wdata[13:8], 2)) & ~pad_oe_b) == 6'h00)
        else $error("drive level wrong");
    uart_capture_a: assert property (uart_rd_s |=>
        reg_rdata[5:0] == ($past(pad_in, 2) & ~pad_analog_en)) else $error("capture wrong");
    idle_read_a: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data without read");
    spare_bits_a: assert property (reg_rd |=> reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0)
        else $error("spare bits set");
endmodule

bind agp_pin_control agp_pin_control_properties #(.NUM_PINS(NUM_PINS)) u_props
(
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_sel(host_sel),
    .uart_addr_parity_end(uart_addr_parity_end), .spi_cs_active(spi_cs_active),
    .spi_sclk_rise(spi_sclk_rise), .spi_read_cmd(spi_read_cmd), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_b(pad_oe_b), .pad_pulldown_en(pad_pulldown_en),
    .pad_analog_en(pad_analog_en)
);

/* File: verification/tb_top.sv */
/*
 * Self-checking bench for the auxiliary pin control block.
 * Assumes the board model resolves pins; clk_en is held high.
 */
`timescale 1ns/1ps
`include "agp_defs.svh"
`define CHK(a, e) check_val(32'(a), 32'(e))

module tb_top;
    logic        ref_clk, rst_b, reg_wr, reg_rd, host_sel, uart_pe, spi_cs, sclk, spi_rd;
    logic [7:0]  reg_addr;  // Register address
    logic [15:0] reg_wdata, reg_rdata;
    logic [5:0]  pad_in, pad_out, pad_oe_b, pad_pd, pad_an, ext_drive, ext_en;
    int          errors, total_checks, cycles;

    agp_pin_control dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .host_sel(host_sel), .uart_addr_parity_end(uart_pe), .spi_cs_active(spi_cs),
        .spi_sclk_rise(sclk), .spi_read_cmd(spi_rd), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_b(pad_oe_b), .pad_pulldown_en(pad_pd), .pad_analog_en(pad_an));
    agp_board_model board (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
        .pad_pulldown_en(pad_pd), .ext_drive(ext_drive), .ext_en(ext_en), .pad_level(pad_in));

    // Compare and count
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register write, then let pads follow
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    // Register read, optionally with a UART capture in the same cycle
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic cap);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        uart_pe <= cap;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        uart_pe <= 1'b0;
        #1 `CHK(reg_rdata, exp);
    endtask
    // Single-cycle SCLK rise events
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            sclk <= 1'b1;
            @(posedge ref_clk);
            sclk <= 1'b0;
        end
    endtask

    // Reset values, pad defaults, unmapped address
    task automatic t_reset();
        `CHK({pad_an, pad_oe_b, pad_pd}, 18'h00fff);
        rd(`AGP_ADDR_MODE_DIR, 16'h3f00, 1'b0);
        rd(`AGP_ADDR_DRIVE_READ, 16'h0000, 1'b0);
        rd(8'h20, 16'h0000, 1'b0);
        $display("test reset done");
    endtask
    // Pins 5:4 analog with direction set, 0 and 2 outputs, UART capture
    task automatic t_modes();
        wr(`AGP_ADDR_MODE_DIR, 16'h0f35);
        `CHK({pad_an, pad_oe_b, pad_pd}, 18'h30e8a);
        wr(`AGP_ADDR_DRIVE_READ, 16'h3f3f);
        `CHK(pad_out & ~pad_oe_b, 6'h05);
        rd(`AGP_ADDR_DRIVE_READ, 16'h3f0f, 1'b1);
        $display("test modes done");
    endtask
    // SPI read: nothing at the eighth rise, capture at the ninth
    task automatic t_spi();
        wr(`AGP_ADDR_DRIVE_READ, 16'h3e3f);
        ext_drive <= 6'h38;
        host_sel <= 1'b0;
        spi_cs <= 1'b1;
        spi_rd <= 1'b1;
        pulses(8);
        rd(`AGP_ADDR_DRIVE_READ, 16'h3e0f, 1'b0);
        pulses(1);
        rd(`AGP_ADDR_DRIVE_READ, 16'h3e0c, 1'b0);
        // A later rise and a stray UART event leave the capture alone
        @(posedge ref_clk);
        ext_drive <= 6'h32;
        pulses(1);
        rd(`AGP_ADDR_DRIVE_READ, 16'h3e0c, 1'b1);
        // A write frame reaches the ninth rise without a capture
        @(posedge ref_clk);
        spi_cs <= 1'b0;
        spi_rd <= 1'b0;
        @(posedge ref_clk);
        spi_cs <= 1'b1;
        pulses(9);
        rd(`AGP_ADDR_DRIVE_READ, 16'h3e0c, 1'b0);
        @(posedge ref_clk);
        spi_cs <= 1'b0;
        $display("test spi done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            errors++;
            finish_test();
        end
    end
    initial
    begin
        {rst_b, reg_wr, reg_rd, uart_pe, spi_cs, sclk, spi_rd} = '0;
        {reg_addr, reg_wdata} = '0;
        host_sel = 1'b1;
        ext_drive = 6'h3a;
        ext_en = 6'h3a;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_reset();
        t_modes();
        t_spi();
        finish_test();
    end
endmodule
